/* tap_scan_sequence_logic.v */
// Boundary-scan TAP sequencing: state controller, instruction and data scans,
// bypass stage and serial output enable.
// Assumes test clock, mode select and serial input arrive from outside the
// ref_clk domain and are sampled here; the test clock is far slower than ref_clk.
//
// Summary of operation
// - On the falling test-clock edge after entering either exit-one state, the serial output is released to high impedance.
// - In update-instruction, the shifted instruction becomes the active instruction on the falling edge.
// - With bypass selected, the bypass stage loads zero on the rising edge that leaves capture-data.
// - On entering a shift state the serial output is enabled on the falling edge and the first bit is taken on the next rising edge.
// - In update-data, the shifted contents go to the selected data register on the falling edge.
// - With bypass selected, each input bit reaches the output one clock later, the captured zero first.
// - Mode select, serial input and parallel inputs are sampled on rising edges and the serial output and its enable change on falling edges.
// - On leaving capture-instruction, the fixed pattern 10000001 is loaded into the instruction stages.
`timescale 1ns/1ps
`include "tap_scan_regs.vh"

module tap_scan_sequence_logic #(
	parameter IR_WIDTH = `IR_WIDTH,
	parameter DR_WIDTH = `DR_WIDTH
) (
	input wire ref_clk,
	input wire nrst,
	input wire clk_en,
	input wire test_clk,
	input wire mode_sel,
	input wire test_din,
	input wire [DR_WIDTH-1:0] parallel_in,
	output reg test_dout,
	output reg test_dout_oe,
	output wire [IR_WIDTH-1:0] active_instr,
	output reg [DR_WIDTH-1:0] data_out,
	output wire bypass_sel,
	output reg [`TAP_STATE_WIDTH-1:0] tap_state
);

////////////////////////////////////////////////////////////////////////////////

reg tck_s1, tck_s2, tck_d;
reg tms_s1, tms_s2;
reg tdi_s1, tdi_s2;
reg [DR_WIDTH-1:0] pin_s1, pin_s2;
wire tck_rise;
wire tck_fall;

// Each off-domain input passes two flops before any logic reads it.
// The edge detector resets to the idle low level of the test clock. A pin held
// low through reset therefore gives no false edge, but a pin that is high at
// release is seen as a rising edge once it reaches the second flop.
always @(posedge ref_clk) begin
	if (!nrst) begin
		tck_s1 <= 1'b0;
		tck_s2 <= 1'b0;
		tck_d <= 1'b0;
		tms_s1 <= 1'b1;
		tms_s2 <= 1'b1;
		tdi_s1 <= 1'b1;
		tdi_s2 <= 1'b1;
		pin_s1 <= {DR_WIDTH{1'b0}};
		pin_s2 <= {DR_WIDTH{1'b0}};
	end else if (clk_en) begin
		tck_s1 <= test_clk;
		tck_s2 <= tck_s1;
		tck_d <= tck_s2;
		tms_s1 <= mode_sel;
		tms_s2 <= tms_s1;
		tdi_s1 <= test_din;
		tdi_s2 <= tdi_s1;
		pin_s1 <= parallel_in;
		pin_s2 <= pin_s1;
	end
end

assign tck_rise = clk_en & tck_s2 & ~tck_d;
assign tck_fall = clk_en & ~tck_s2 & tck_d;

////////////////////////////////////////////////////////////////////////////////

reg [`TAP_STATE_WIDTH-1:0] next_tap_state;

// An illegal code falls back to test-logic-reset. A held-high mode select
// leads there from any state within five rising edges as well.
always @* begin
	case (tap_state)
	`ST_RESET: next_tap_state = tms_s2 ? `ST_RESET : `ST_IDLE;
	`ST_IDLE: next_tap_state = tms_s2 ? `ST_SEL_DR : `ST_IDLE;
	`ST_SEL_DR: next_tap_state = tms_s2 ? `ST_SEL_IR : `ST_CAP_DR;
	`ST_CAP_DR: next_tap_state = tms_s2 ? `ST_EXIT1_DR : `ST_SHIFT_DR;
	`ST_SHIFT_DR: next_tap_state = tms_s2 ? `ST_EXIT1_DR : `ST_SHIFT_DR;
	`ST_EXIT1_DR: next_tap_state = tms_s2 ? `ST_UPD_DR : `ST_PAUSE_DR;
	`ST_PAUSE_DR: next_tap_state = tms_s2 ? `ST_EXIT2_DR : `ST_PAUSE_DR;
	`ST_EXIT2_DR: next_tap_state = tms_s2 ? `ST_UPD_DR : `ST_SHIFT_DR;
	`ST_UPD_DR: next_tap_state = tms_s2 ? `ST_SEL_DR : `ST_IDLE;
	`ST_SEL_IR: next_tap_state = tms_s2 ? `ST_RESET : `ST_CAP_IR;
	`ST_CAP_IR: next_tap_state = tms_s2 ? `ST_EXIT1_IR : `ST_SHIFT_IR;
	`ST_SHIFT_IR: next_tap_state = tms_s2 ? `ST_EXIT1_IR : `ST_SHIFT_IR;
	`ST_EXIT1_IR: next_tap_state = tms_s2 ? `ST_UPD_IR : `ST_PAUSE_IR;
	`ST_PAUSE_IR: next_tap_state = tms_s2 ? `ST_EXIT2_IR : `ST_PAUSE_IR;
	`ST_EXIT2_IR: next_tap_state = tms_s2 ? `ST_UPD_IR : `ST_SHIFT_IR;
	`ST_UPD_IR: next_tap_state = tms_s2 ? `ST_SEL_DR : `ST_IDLE;
	default: next_tap_state = `ST_RESET;
	endcase
end

// The controller advances only on rising test-clock edges; mode select is
// expected to change on the falling edge, well clear of the sample point.
always @(posedge ref_clk) begin
	if (!nrst)
		tap_state <= `ST_RESET;
	else if (tck_rise)
		tap_state <= next_tap_state;
end

////////////////////////////////////////////////////////////////////////////////

wire in_reset = tap_state == `ST_RESET;
wire ir_serial;
wire dr_serial;
reg bypass_stage;
wire [IR_WIDTH-1:0] ir_held;
wire [DR_WIDTH-1:0] dr_held;

// An action strobe: one detected test-clock edge qualified by one TAP state.
function on_edge_in;
	input detected_edge;
	input [`TAP_STATE_WIDTH-1:0] current;
	input [`TAP_STATE_WIDTH-1:0] wanted;
	begin
		on_edge_in = detected_edge && current == wanted;
	end
endfunction

// One strobe per scan action. Each is high for exactly one ref_clk cycle per
// test-clock edge, so a slow test clock can never load or shift twice.
wire ir_load = on_edge_in(tck_rise, tap_state, `ST_CAP_IR);
wire ir_shift = on_edge_in(tck_rise, tap_state, `ST_SHIFT_IR);
wire ir_update = on_edge_in(tck_fall, tap_state, `ST_UPD_IR);
wire dr_capture = on_edge_in(tck_rise, tap_state, `ST_CAP_DR);
wire dr_shift = on_edge_in(tck_rise, tap_state, `ST_SHIFT_DR);
wire dr_update = on_edge_in(tck_fall, tap_state, `ST_UPD_DR);

// Shift-register loads and shifts happen on the rising edge that leaves the
// capture or shift state, so the state decode uses the current state.
scan_shift_reg #(
	.WIDTH(IR_WIDTH),
	.RESET_VALUE(`IR_RESET_VALUE)
) u_ir (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.clk_en(clk_en),
	.load(ir_load),
	.load_value(`IR_CAPTURE_PATTERN),
	.shift(ir_shift),
	.serial_in(tdi_s2),
	.update(ir_update),
	.serial_out(ir_serial),
	.held(ir_held)
);

// A reset state forces the instruction back to bypass, as a TAP must.
reg ir_force_bypass;
always @(posedge ref_clk) begin
	if (!nrst)
		ir_force_bypass <= 1'b1;
	else if (ir_update)
		ir_force_bypass <= 1'b0;
	else if (clk_en && in_reset)
		ir_force_bypass <= 1'b1;
end

assign active_instr = ir_force_bypass ? `IR_BYPASS_CODE : ir_held;
assign bypass_sel = active_instr == `IR_BYPASS_CODE;

// Any non-bypass instruction selects a general data register that captures
// the sampled parallel inputs.
scan_shift_reg #(
	.WIDTH(DR_WIDTH),
	.RESET_VALUE(`DR_RESET_VALUE)
) u_dr (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.clk_en(clk_en),
	.load(dr_capture && !bypass_sel),
	.load_value(pin_s2),
	.shift(dr_shift && !bypass_sel),
	.serial_in(tdi_s2),
	.update(dr_update && !bypass_sel),
	.serial_out(dr_serial),
	.held(dr_held)
);

always @(posedge ref_clk) begin
	if (!nrst)
		bypass_stage <= 1'b0;
	else if (dr_capture && bypass_sel)
		bypass_stage <= 1'b0;
	else if (dr_shift && bypass_sel)
		bypass_stage <= tdi_s2;
end

// The update latch of the data register already holds the result and resets
// to the documented value; passing it straight out means the two never differ.
always @* begin
	data_out = dr_held;
end

////////////////////////////////////////////////////////////////////////////////

// Output changes only on falling edges so the controller can sample it on
// the next rising edge with a full half period of margin.
// While the enable is low the data bit keeps its last value; the pad that it
// feeds turns it into high impedance, so nothing may rely on it there.
wire in_shift = tap_state == `ST_SHIFT_IR || tap_state == `ST_SHIFT_DR;
wire shift_bit = (tap_state == `ST_SHIFT_IR) ? ir_serial :
	(bypass_sel ? bypass_stage : dr_serial);

always @(posedge ref_clk) begin
	if (!nrst) begin
		test_dout <= 1'b0;
		test_dout_oe <= 1'b0;
	end else if (tck_fall) begin
		test_dout_oe <= in_shift;
		if (in_shift)
			test_dout <= shift_bit;
	end
end

endmodule // tap_scan_sequence_logic

/* tap_scan_regs.vh */
// Constants for the boundary-scan sequencing block: TAP state codes, instruction
// register layout, capture pattern and reset values.
// Assumes inclusion by plain Verilog-2005 design files.
`ifndef TAP_SCAN_REGS_VH
`define TAP_SCAN_REGS_VH

`define IR_WIDTH 8
`define IR_CAPTURE_PATTERN 8'h81
`define IR_BYPASS_CODE 8'hFF
`define IR_RESET_VALUE 8'hFF
`define DR_WIDTH 8
`define DR_RESET_VALUE 8'h00
`define TAP_STATE_WIDTH 16

// One-hot TAP state codes.
`define ST_RESET 16'h0001
`define ST_IDLE 16'h0002
`define ST_SEL_DR 16'h0004
`define ST_CAP_DR 16'h0008
`define ST_SHIFT_DR 16'h0010
`define ST_EXIT1_DR 16'h0020
`define ST_PAUSE_DR 16'h0040
`define ST_EXIT2_DR 16'h0080
`define ST_UPD_DR 16'h0100
`define ST_SEL_IR 16'h0200
`define ST_CAP_IR 16'h0400
`define ST_SHIFT_IR 16'h0800
`define ST_EXIT1_IR 16'h1000
`define ST_PAUSE_IR 16'h2000
`define ST_EXIT2_IR 16'h4000
`define ST_UPD_IR 16'h8000

`endif

/* scan_shift_reg.v */
// Parallel-load serial shift stage with an update latch taken on a strobe.
// Assumes load, shift and update strobes from the controller on the same clock.
`timescale 1ns/1ps

module scan_shift_reg #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	input wire ref_clk,
	input wire nrst,
	input wire clk_en,
	input wire load,
	input wire [WIDTH-1:0] load_value,
	input wire shift,
	input wire serial_in,
	input wire update,
	output wire serial_out,
	output reg [WIDTH-1:0] held
);

reg [WIDTH-1:0] stages;

assign serial_out = stages[0];

always @(posedge ref_clk) begin
	if (!nrst) begin
		stages <= {WIDTH{1'b0}};
		held <= RESET_VALUE;
	end else if (clk_en) begin
		if (load)
			stages <= load_value;
		else if (shift)
			stages <= {serial_in, stages[WIDTH-1:1]};
		if (update)
			held <= stages;
	end
end

endmodule // scan_shift_reg

/* tap_scan_checker_asserts.sv */
// Pin-level timing checks for the TAP sequencing block.
// Assumes test clock phases of at least four ref_clk cycles.
`timescale 1ns/1ps
`include "tap_scan_regs.vh"
module tap_scan_checker #(
	parameter IR_WIDTH = 8,
	parameter DR_WIDTH = 8
) (
	input wire ref_clk,
	input wire nrst,
	input wire test_clk,
	input wire [DR_WIDTH-1:0] parallel_in,
	input wire test_dout,
	input wire test_dout_oe,
	input wire [IR_WIDTH-1:0] active_instr,
	input wire [DR_WIDTH-1:0] data_out,
	input wire bypass_sel,
	input wire [15:0] tap_state
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
wire shift_st = tap_state == `ST_SHIFT_IR || tap_state == `ST_SHIFT_DR;
wire exit_st = tap_state == `ST_EXIT1_IR || tap_state == `ST_EXIT1_DR;
a_oe_off_exit:
	assert property ($rose(exit_st) |-> ##[1:40] !test_dout_oe) else $error("oe held in exit");
a_instr_update:
	assert property (!$stable(active_instr) |-> tap_state == `ST_UPD_IR
		|| tap_state == `ST_RESET) else $error("instruction changed early");
a_bypass_zero:
	assert property ($rose(test_dout_oe) && tap_state == `ST_SHIFT_DR && bypass_sel
		|-> !test_dout) else $error("bypass did not capture zero");
a_oe_on_shift:
	assert property ($rose(shift_st) |-> ##[1:40] test_dout_oe) else $error("oe not raised");
a_oe_in_scan:
	assert property (test_dout_oe |-> shift_st || exit_st) else $error("oe outside shift");
a_data_update:
	assert property (!$stable(data_out) |-> tap_state == `ST_UPD_DR) else $error("data early");
a_dout_on_fall:
	assert property (!$stable(test_dout) || !$stable(test_dout_oe) |-> !$past(test_clk, 2))
		else $error("output changed off falling edge");
a_ir_pattern:
	assert property ($rose(test_dout_oe) && tap_state == `ST_SHIFT_IR |-> test_dout)
		else $error("capture pattern wrong");
c_upd_ir: cover property (tap_state == `ST_UPD_IR);
c_byp: cover property ($rose(test_dout_oe) && bypass_sel && tap_state == `ST_SHIFT_DR);
c_upd_dr: cover property (tap_state == `ST_UPD_DR && !bypass_sel);
endmodule // tap_scan_checker
bind tap_scan_sequence_logic tap_scan_checker #(.IR_WIDTH(IR_WIDTH), .DR_WIDTH(DR_WIDTH))
	i_tap_scan_checker (.ref_clk(ref_clk), .nrst(nrst), .test_clk(test_clk),
	.parallel_in(parallel_in), .test_dout(test_dout), .test_dout_oe(test_dout_oe),
	.active_instr(active_instr), .data_out(data_out), .bypass_sel(bypass_sel),
	.tap_state(tap_state));

/* tap_ctrl_model.sv */
// Behavioural external test controller: test clock, mode select, serial input.
// Assumes one step call per test clock period, entered just after a ref_clk edge.
`timescale 1ns/1ps
module tap_ctrl_model (
	input wire ref_clk,
	input wire test_dout,
	input wire test_dout_oe,
	output reg test_clk,
	output reg mode_sel,
	output reg test_din
);
// The serial output has no pull on this link, so a released line shows the
// inverse of the last bit and a read of it can never pass by accident.
wire tdo_seen = test_dout_oe ? test_dout : ~test_dout;
initial begin
	test_clk = 1'b0;
	mode_sel = 1'b1;
	test_din = 1'b1;
end
// The clock is left high between calls and falls as the next call begins; h is
// the length of each phase in ref_clk cycles and must be at least four.
task step(input logic m, input logic d, input int h, output logic o, output logic oe);
	test_clk = 1'b0;
	mode_sel = m;
	test_din = d;
	repeat (h) @(posedge ref_clk);
	#1 test_clk = 1'b1;
	repeat (h) @(posedge ref_clk);
	#1 o = tdo_seen;
	oe = test_dout_oe;
endtask
endmodule // tap_ctrl_model

/* tap_scan_sequence_logic_test.sv */
// Self-checking bench: IR and DR scans, bypass and return to reset.
// Assumes a 100 MHz ref_clk and the controller model for the test pins.
`timescale 1ns/1ps
`include "tap_scan_regs.vh"
module tap_scan_sequence_logic_test;
reg ref_clk = 1'b0;
reg nrst = 1'b0;
reg clk_en = 1'b1;
reg [7:0] parallel_in = 8'h00;
wire test_clk, mode_sel, test_din, test_dout, test_dout_oe, bypass_sel;
wire [7:0] active_instr, data_out;
wire [15:0] tap_state;
int num_errors = 0;
int total_checks = 0;
int h = 4;
logic o, oe;
always #5 ref_clk = ~ref_clk;
tap_scan_sequence_logic i_tap_scan_sequence_logic (.ref_clk(ref_clk), .nrst(nrst),
	.clk_en(clk_en), .test_clk(test_clk), .mode_sel(mode_sel), .test_din(test_din),
	.parallel_in(parallel_in), .test_dout(test_dout), .test_dout_oe(test_dout_oe),
	.active_instr(active_instr), .data_out(data_out), .bypass_sel(bypass_sel),
	.tap_state(tap_state));
tap_ctrl_model i_tap_ctrl_model (.ref_clk(ref_clk), .test_dout(test_dout),
	.test_dout_oe(test_dout_oe), .test_clk(test_clk), .mode_sel(mode_sel),
	.test_din(test_din));
////////////////////////////////////////////////////////////////////////////////
task check(input logic ok, input string msg);
	total_checks++;
	if (!ok) begin
		num_errors++;
		$display("ERROR %0t %s", $time, msg);
	end
endtask
task st(input logic m, input logic d);
	i_tap_ctrl_model.step(m, d, h, o, oe);
endtask
// Starts and ends in idle; bits go in and come out LSB first.
task scan(input logic ir, input [7:0] din_v, input [7:0] exp, input int n);
	st(1'b1, 1'b1);
	if (ir) st(1'b1, 1'b1);
	st(1'b0, 1'b1);
	st(1'b0, 1'b1);
	for (int i = 0; i < n; i++) begin
		st(i == n - 1, din_v[i]);
		check(oe === 1'b1 && o === exp[i], "serial out");
	end
	st(1'b1, 1'b1);
	check(oe === 1'b0, "oe in exit");
	st(1'b0, 1'b1);
endtask
task t_ir_load;
	st(1'b0, 1'b1);
	scan(1'b1, 8'h01, 8'h81, 8);
	check(active_instr === 8'h01 && bypass_sel === 1'b0, "ir update");
endtask
task t_dr_update;
	parallel_in = 8'h5a;
	scan(1'b0, 8'hc3, 8'h5a, 8);
	check(data_out === 8'hc3, "dr update");
endtask
task t_bypass;
	h = 8;
	scan(1'b1, 8'hff, 8'h81, 8);
	check(bypass_sel === 1'b1, "bypass");
	scan(1'b0, 8'h05, 8'h02, 3);
	check(data_out === 8'hc3, "bypass kept dr");
	h = 4;
endtask
// A low clock enable must hide a whole test-clock cycle from the block.
task t_freeze;
	clk_en = 1'b0;
	st(1'b1, 1'b1);
	clk_en = 1'b1;
	check(tap_state === `ST_IDLE, "moved while frozen");
	st(1'b0, 1'b1);
	check(tap_state === `ST_IDLE, "lost idle after freeze");
endtask
// With bypass active: capture straight to exit-one, then update-data, and
// from there three high mode-select edges lead back to reset.
task t_finish;
	st(1'b1, 1'b1);
	st(1'b0, 1'b1);
	st(1'b1, 1'b1);
	st(1'b1, 1'b1);
	check(tap_state === `ST_UPD_DR, "no update-data");
	repeat (3) st(1'b1, 1'b1);
	check(tap_state === `ST_RESET && active_instr === `IR_BYPASS_CODE, "no reset");
endtask
task results;
	$display("checks %0d errors %0d", total_checks, num_errors);
	if (num_errors == 0 && total_checks > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	repeat (8) @(posedge ref_clk);
	#1 nrst = 1'b1;
	t_ir_load();
	t_dr_update();
	t_freeze();
	t_bypass();
	t_finish();
	results();
end
initial begin
	repeat (20000) @(posedge ref_clk);
	num_errors++;
	results();
end
endmodule // tap_scan_sequence_logic_test
